// ==== hw/tbg_core.sv ====
// burst generator and drive fault monitor with apb registers
`timescale 1ns/100ps
`include "tbg_map.svh"
module tbg_core
  import tbg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_control_pin,
  input  wire logic        second_control_pin,
  output logic             drive_output_a,
  output logic             drive_output_b,
  output logic      [2:0]  drive_current_limit_level,
  output logic             pulse_count_fault_flag,
  output logic             stuck_drive_fault_flag
);
  tbg_ctrl_type               ctrl_r, ctrl_nxt;
  tbg_burst_type              burst_r, burst_nxt;
  tbg_state_type              state_r, state_nxt;
  logic [31:0]                prdata_r, prdata_nxt;
  logic [1:0]                 io1_s_r, io2_s_r;
  logic                       io1_d_r, io2_d_r;
  logic                       trig_d_r;
  logic [`TBG_CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [`TBG_TMR_W-1:0]      tmr_r, tmr_nxt, tmr_lim;
  logic                       pcf_r, pcf_nxt, sdf_r, sdf_nxt;
  logic                       out_a_r, out_a_nxt, out_b_r, out_b_nxt;
  logic                       io1, io2, io1_fall, io2_fall, trig_rise;
  logic                       wr, setup, hit, wr_ctrl, wr_burst;
  logic                       ft_clr, stby_ent;
  logic                       start, pcf_set, sdf_set, tgl, reached, host_end, stuck;
  logic [1:0]                 md;
  logic [`TBG_CNT_W-1:0]      tgt;

  // two-stage pin synchronisers
  // clean edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // pins idle high, so no false edge after reset
      io1_s_r <= '1;
      io2_s_r <= '1;
      io1_d_r <= 1'b1;
      io2_d_r <= 1'b1;
    end else begin
      io1_s_r <= {io1_s_r[0], first_control_pin};
      io2_s_r <= {io2_s_r[0], second_control_pin};
      io1_d_r <= io1_s_r[1];
      io2_d_r <= io2_s_r[1];
    end
  end

  assign io1      = io1_s_r[1];
  assign io2      = io2_s_r[1];
  assign io1_fall = io1_d_r & ~io1;
  assign io2_fall = io2_d_r & ~io2;

  // apb slave, zero wait states
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pwrite;
  assign hit      = (paddr == `TBG_A_CTRL) || (paddr == `TBG_A_BURST) ||
                    (paddr == `TBG_A_STAT);
  assign wr_ctrl  = wr && (paddr == `TBG_A_CTRL);
  assign wr_burst = wr && (paddr == `TBG_A_BURST);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = prdata_r;
  assign ft_clr   = wr_burst && (pwdata[`TBG_B_FT] == `TBG_FT_CLR);
  assign stby_ent = wr_ctrl && pwdata[$bits(tbg_ctrl_type)-1] && !ctrl_r.stby;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    burst_nxt  = burst_r;
    prdata_nxt = prdata_r;
    if (wr_ctrl) begin
      ctrl_nxt = tbg_ctrl_type'(pwdata[$bits(tbg_ctrl_type)-1:0]);
    end
    if (wr_burst) begin
      burst_nxt     = tbg_burst_type'(pwdata[$bits(tbg_burst_type)-1:0]);
      burst_nxt.pad = '0;
    end
    if (setup) begin
      prdata_nxt = '0;
      if (paddr == `TBG_A_CTRL) begin
        prdata_nxt[$bits(tbg_ctrl_type)-1:0] = ctrl_r;
      end else if (paddr == `TBG_A_BURST) begin
        prdata_nxt[$bits(tbg_burst_type)-1:0] = burst_r;
      end else if (paddr == `TBG_A_STAT) begin
        prdata_nxt[`TBG_S_PCF] = pcf_r;
        prdata_nxt[`TBG_S_SDF] = sdf_r;
        prdata_nxt[`TBG_S_ST]  = state_r;
        prdata_nxt[`TBG_S_CNT] = cnt_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= tbg_ctrl_type'(`TBG_CTRL_RST);
      burst_r  <= tbg_burst_type'(`TBG_BURST_RST);
      prdata_r <= '0;
      trig_d_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      burst_r  <= burst_nxt;
      prdata_r <= prdata_nxt;
      trig_d_r <= ctrl_r.trig;
    end
  end

  assign md        = ctrl_r.mode;
  assign tgt       = burst_r.cnt;
  assign trig_rise = ctrl_r.trig & ~trig_d_r;
  assign tmr_lim   = `TBG_TMR_W'((32'(burst_r.ft) + 32'd1) * `TBG_FT_STEP_CYC);
  assign tgl       = (md == `TBG_M2) ? ((io1 != io1_d_r) || (io2 != io2_d_r))
                                     : (io2 != io2_d_r);

  // burst sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    tmr_nxt   = tmr_r;
    start     = 1'b0;
    pcf_set   = 1'b0;
    sdf_set   = 1'b0;
    reached   = 1'b0;
    host_end  = 1'b0;
    stuck     = 1'b0;
    unique case (state_r)
      ST_LISTEN: begin
        cnt_nxt = '0;
        tmr_nxt = '0;
        if (md == `TBG_M0 && trig_rise) state_nxt = ST_ARMED;
        if (md == `TBG_M1 && io1_fall) state_nxt = ST_ARMED;
        if (md == `TBG_M2 && (io1_fall || io2_fall)) state_nxt = ST_ARMED;
        if (md == `TBG_M3 && io2_fall) begin
          start = 1'b1;
          state_nxt = (tgt == '0) ? ST_BLANK : ST_BURST;
        end
      end
      ST_ARMED: begin
        tmr_nxt = '0;
        if ((md == `TBG_M2) ? io1_fall : io2_fall) begin
          start     = 1'b1;
          state_nxt = ST_BURST;
        end
        if ((md == `TBG_M0 && !ctrl_r.trig) || (md == `TBG_M1 && io1) ||
            (md == `TBG_M3)) begin
          start     = 1'b0;
          state_nxt = ST_LISTEN;
        end
      end
      ST_BURST: begin
        tmr_nxt = tgl ? '0 : `TBG_TMR_W'(tmr_r + 1'b1);
        if (io2_fall && md != `TBG_M2) cnt_nxt = `TBG_CNT_W'(cnt_r + 1'b1);
        reached  = (md != `TBG_M2) && (tgt != '0) && (cnt_nxt == tgt);
        host_end = (md == `TBG_M0 && !ctrl_r.trig) || (md == `TBG_M1 && io1) ||
                   (md == `TBG_M2 && io1 && io2);
        stuck    = !tgl && (tmr_nxt >= tmr_lim);
        if (reached || host_end || stuck) begin
          state_nxt = (md == `TBG_M3) ? ST_BLANK : ST_LISTEN;
          tmr_nxt   = '0;
          sdf_set   = stuck && !reached;
          pcf_set   = (md != `TBG_M2) && !reached && (cnt_nxt < tgt);
        end
      end
      ST_BLANK: begin
        tmr_nxt = `TBG_TMR_W'(tmr_r + 1'b1);
        if (tmr_nxt >= tmr_lim) state_nxt = ST_LISTEN;
      end
    endcase
    if (ctrl_r.stby) begin
      state_nxt = ST_LISTEN;
      start     = 1'b0;
      pcf_set   = 1'b0;
      sdf_set   = 1'b0;
    end
  end

  // flags: set wins over clear
  always_comb begin
    pcf_nxt = pcf_set | (pcf_r & ~(start | stby_ent));
    sdf_nxt = sdf_set | (sdf_r & ~(start | stby_ent | ft_clr));
  end

  always_comb begin
    out_a_nxt = 1'b0;
    out_b_nxt = 1'b0;
    if (state_r == ST_BURST) begin
      if (md == `TBG_M2) begin
        out_a_nxt = ~io1;
        out_b_nxt = ~io2;
      end else if (ctrl_r.inph) begin
        out_a_nxt = ~io2;
        out_b_nxt = ~io2;
      end else begin
        out_a_nxt = ~io2;
        out_b_nxt = io2;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_LISTEN;
      cnt_r   <= '0;
      tmr_r   <= '0;
      pcf_r   <= 1'b0;
      sdf_r   <= 1'b0;
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      tmr_r   <= tmr_nxt;
      pcf_r   <= pcf_nxt;
      sdf_r   <= sdf_nxt;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
    end
  end

  assign drive_output_a            = out_a_r;
  assign drive_output_b            = out_b_r;
  // same limit in either drive mode
  assign drive_current_limit_level = ctrl_r.ilim;
  assign pulse_count_fault_flag    = pcf_r;
  assign stuck_drive_fault_flag    = sdf_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_m3_start;
    state_r == ST_LISTEN && md == `TBG_M3 && io2_fall && !ctrl_r.stby;
  endsequence
  sequence s_in_burst;
    state_r == ST_BURST && !ctrl_r.stby;
  endsequence

  m3_start_a: assert property (s_m3_start and tgt != '0 |=> state_r == ST_BURST)
    else $error("mode 3 edge did not start burst");
  pulse_count_a: assert property (s_in_burst and io2_fall && md != `TBG_M2
      && state_nxt == ST_BURST |=> cnt_r == `TBG_CNT_W'($past(cnt_r) + 1'b1))
    else $error("pulse not counted");
  m3_end_a: assert property (s_in_burst and md == `TBG_M3 && io2_fall
      && `TBG_CNT_W'(cnt_r + 1'b1) == tgt |=> state_r == ST_BLANK ##1 state_r != ST_BURST)
    else $error("mode 3 burst not ended at count");
  blank_hold_a: assert property (state_r == ST_BLANK |=> state_r != ST_BURST)
    else $error("burst started during blank-out");
  m0_cont_a: assert property (s_in_burst and md == `TBG_M0 && tgt == '0
      && ctrl_r.trig && io2_fall |=> state_r == ST_BURST)
    else $error("continuous burst stopped");
  m3_zero_a: assert property (s_m3_start and tgt == '0 |=> state_r == ST_BLANK)
    else $error("mode 3 zero count entered burst");
  idle_out_a: assert property (state_r != ST_BURST |=> !out_a_r && !out_b_r)
    else $error("outputs driven outside burst");
  short_burst_a: assert property (s_in_burst and md == `TBG_M0 && !ctrl_r.trig
      && !io2_fall && cnt_r < tgt |=> pulse_count_fault_flag)
    else $error("short burst not flagged");
  stuck_end_a: assert property (s_in_burst and md != `TBG_M2 && io2 == io2_d_r
      && `TBG_TMR_W'(tmr_r + 1'b1) >= tmr_lim && cnt_r < tgt
      |=> stuck_drive_fault_flag && pulse_count_fault_flag && state_r != ST_BURST)
    else $error("stuck drive not caught");
  sdf_clr_a: assert property (ft_clr && !sdf_set |=> !stuck_drive_fault_flag)
    else $error("stuck fault not cleared");
  pcf_keep_a: assert property (pcf_r && !start && !stby_ent |=> pcf_r)
    else $error("pulse count fault lost");
  center_tap_a: assert property (s_in_burst and md != `TBG_M2 && !ctrl_r.inph
      |=> drive_output_a != drive_output_b)
    else $error("center-tap outputs not opposite");
  in_phase_a: assert property (s_in_burst and md != `TBG_M2 && ctrl_r.inph
      |=> drive_output_a == drive_output_b)
    else $error("in-phase outputs differ");
endmodule

// ==== hw/tbg_map.svh ====
// register map, field positions and timing constants of the burst generator
`ifndef TBG_MAP_SVH
`define TBG_MAP_SVH
`define TBG_A_CTRL      8'h00
`define TBG_A_BURST     8'h04
`define TBG_A_STAT      8'h08
`define TBG_CTRL_RST    8'h00
`define TBG_BURST_RST   11'h000
`define TBG_B_FT        10:8
`define TBG_FT_CLR      3'h7
`define TBG_S_PCF       0
`define TBG_S_SDF       1
`define TBG_S_ST        3:2
`define TBG_S_CNT       9:4
`define TBG_M0          2'h0
`define TBG_M1          2'h1
`define TBG_M2          2'h2
`define TBG_M3          2'h3
`define TBG_CLK_NS      5
`define TBG_FT_STEP_NS  1000
`define TBG_FT_STEP_CYC ((`TBG_FT_STEP_NS + `TBG_CLK_NS - 1) / `TBG_CLK_NS)
`define TBG_TMR_W       11
`define TBG_CNT_W       6
`endif

// ==== hw/tbg_pkg.sv ====
// types shared by the burst generator
package tbg_pkg;
  typedef enum logic [1:0] {ST_LISTEN, ST_ARMED, ST_BURST, ST_BLANK} tbg_state_type;
  typedef struct packed {
    logic       stby;
    logic [2:0] ilim;
    logic       inph;
    logic       trig;
    logic [1:0] mode;
  } tbg_ctrl_type;
  typedef struct packed {
    logic [2:0] ft;
    logic [1:0] pad;
    logic [5:0] cnt;
  } tbg_burst_type;
endpackage

// ==== testbench/tb_transducer_burst_generator.sv ====
// self-checking bench of the burst generator
`timescale 1ns/100ps
`include "tbg_map.svh"
module tb_transducer_burst_generator;
  import tbg_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        io1, io2, out_a, out_b, pcf, sdf;
  logic [2:0]  ilim;
  int          failures, compares, seed, n, e_pcf, e_sdf, e_st, e_cnt;

  tbg_core dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_control_pin(io1),
    .second_control_pin(io2), .drive_output_a(out_a), .drive_output_b(out_b),
    .drive_current_limit_level(ilim), .pulse_count_fault_flag(pcf),
    .stuck_drive_fault_flag(sdf));
  tbg_mcu_model mcu (.first_control_pin(io1), .second_control_pin(io2));

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7fffffff;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'h1 && t < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'h1) failures++;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(w, rd, e);
  endtask
  task automatic ctl(input logic [1:0] m, input logic tr, input logic ip, input logic [2:0] il,
                     input logic sb);
    tbg_ctrl_type c;
    c = {sb, il, ip, tr, m};
    apb(1'h1, `TBG_A_CTRL, {24'h0, c});
  endtask
  task automatic bst(input logic [2:0] ft, input logic [5:0] cnt);
    apb(1'h1, `TBG_A_BURST, {21'h0, ft, 2'h0, cnt});
  endtask
  // model state compared with status register and flag pins
  task automatic stat();
    logic [31:0] m, e;
    m = (e_cnt < 0) ? 32'hfffffc0f : 32'hffffffff;
    e = {22'h0, e_cnt[5:0], e_st[1:0], e_sdf[0], e_pcf[0]};
    apb(1'h0, `TBG_A_STAT, 32'h0);
    check("status", rd & m, e & m);
    check("flag pins", {30'h0, sdf, pcf}, {30'h0, e_sdf[0], e_pcf[0]});
  endtask
  task automatic outs(input logic a, input logic b);
    check("drive outputs", {30'h0, out_a, out_b}, {30'h0, a, b});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    {failures, compares, e_pcf, e_sdf, e_st, e_cnt} = '0;
    seed = 61;
    {rst_n, psel, penable, pwrite, paddr} = '0;
    pwdata = rnd();
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    cyc(3);
    rchk("ctrl reset", `TBG_A_CTRL, 32'h0);
    rchk("burst reset", `TBG_A_BURST, 32'h0);
    stat();
    rchk("unmapped", 8'h0c, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      ctl(i[1:0], 1'h0, i[0], i[2:0], 1'h0);
      check("ilim", {29'h0, ilim}, i);
      rchk("ctrl", `TBG_A_CTRL, {25'h0, i[2:0], i[0], 1'h0, i[1:0]});
    end
    // mode 3, random count, center-tap
    n = 1 + rnd() % 6;
    bst(3'h0, n[5:0]);
    ctl(`TBG_M3, 1'h0, 1'h0, 3'h2, 1'h0);
    mcu.set_pin(2, 1'h0);
    cyc(20);
    e_st = 2;
    stat();
    outs(1'h1, 1'h0);
    mcu.set_pin(2, 1'h1);
    cyc(20);
    outs(1'h0, 1'h1);
    mcu.pulses(n);
    cyc(10);
    e_st = 3;
    e_cnt = n;
    stat();
    mcu.pulses(2);
    cyc(10);
    stat();
    cyc(220);
    e_st = 0;
    e_cnt = -1;
    stat();
    outs(1'h0, 1'h0);
    // in-phase drive
    bst(3'h0, 6'h01);
    ctl(`TBG_M3, 1'h0, 1'h1, 3'h2, 1'h0);
    mcu.set_pin(2, 1'h0);
    cyc(20);
    outs(1'h1, 1'h1);
    mcu.set_pin(2, 1'h1);
    cyc(20);
    outs(1'h0, 1'h0);
    mcu.pulses(1);
    cyc(10);
    e_st = 3;
    e_cnt = 1;
    stat();
    cyc(220);
    // stuck pin ends burst after (0+1)*200 clk
    bst(3'h0, 6'h04);
    ctl(`TBG_M3, 1'h0, 1'h0, 3'h2, 1'h0);
    mcu.set_pin(2, 1'h0);
    cyc(140);
    e_st = 2;
    e_cnt = 0;
    stat();
    cyc(500);
    {e_sdf, e_pcf, e_st, e_cnt} = {32'd1, 32'd1, 32'd0, -32'd1};
    stat();
    mcu.set_pin(2, 1'h1);
    bst(3'h7, 6'h04);
    e_sdf = 0;
    stat();
    ctl(`TBG_M3, 1'h0, 1'h0, 3'h2, 1'h1);
    e_pcf = 0;
    stat();
    // mode 0, count 0 runs until trigger clears
    bst(3'h7, 6'h00);
    ctl(`TBG_M0, 1'h1, 1'h0, 3'h2, 1'h0);
    mcu.pulses(10);
    cyc(10);
    e_st = 2;
    stat();
    ctl(`TBG_M0, 1'h0, 1'h0, 3'h2, 1'h0);
    e_st = 0;
    stat();
    // mode 0 ended early by trigger
    bst(3'h7, 6'h05);
    ctl(`TBG_M0, 1'h1, 1'h0, 3'h2, 1'h0);
    mcu.pulses(3);
    cyc(10);
    e_st = 2;
    e_cnt = 2;
    stat();
    ctl(`TBG_M0, 1'h0, 1'h0, 3'h2, 1'h0);
    {e_pcf, e_st, e_cnt} = {32'd1, 32'd0, -32'd1};
    stat();
    // mode 1: full count, then early end by first pin
    bst(3'h7, 6'h03);
    ctl(`TBG_M1, 1'h0, 1'h0, 3'h2, 1'h0);
    mcu.set_pin(1, 1'h0);
    mcu.pulses(4);
    cyc(10);
    e_pcf = 0;
    stat();
    mcu.set_pin(1, 1'h1);
    cyc(10);
    mcu.set_pin(1, 1'h0);
    mcu.pulses(2);
    cyc(10);
    e_st = 2;
    stat();
    mcu.set_pin(1, 1'h1);
    cyc(10);
    e_st = 0;
    e_pcf = 1;
    stat();
    // mode 3 count 0 never bursts, goes straight to blank-out
    bst(3'h0, 6'h00);
    ctl(`TBG_M3, 1'h0, 1'h0, 3'h2, 1'h0);
    n = rnd();
    // random first pin level, ignored in mode 3
    mcu.set_pin(1, n[0]);
    mcu.set_pin(2, 1'h0);
    cyc(20);
    e_st = 3;
    e_pcf = 0;
    stat();
    mcu.set_pin(2, 1'h1);
    cyc(250);
    // mode 2: either pin arms, first pin starts, both high ends
    mcu.set_pin(1, 1'h1);
    ctl(`TBG_M2, 1'h0, 1'h0, 3'h2, 1'h0);
    mcu.set_pin(2, 1'h0);
    cyc(10);
    e_st = 1;
    stat();
    mcu.set_pin(1, 1'h0);
    cyc(10);
    e_st = 2;
    stat();
    outs(1'h1, 1'h1);
    mcu.set_pin(2, 1'h1);
    cyc(10);
    outs(1'h1, 1'h0);
    mcu.set_pin(1, 1'h1);
    cyc(10);
    e_st = 0;
    stat();
    outs(1'h0, 1'h0);
    print_verdict();
  end
endmodule

// ==== testbench/tbg_mcu_model.sv ====
// microcontroller model driving the two control pins
`timescale 1ns/100ps
module tbg_mcu_model (
  output logic first_control_pin,
  output logic second_control_pin
);
  // both pins pulled up, link clock stands still between frames
  initial begin
    first_control_pin = 1'h1;
    second_control_pin = 1'h1;
  end
  // first pin low enables a mode 1 burst, high ends it
  task automatic set_pin(input int which, input logic v);
    if (which == 1) begin
      first_control_pin <= v;
    end else begin
      second_control_pin <= v;
    end
  endtask
  // transducer clock of 48 ns, one falling edge per pulse
  task automatic pulses(input int n);
    repeat (n) begin
      #24 second_control_pin <= 1'h0;
      #24 second_control_pin <= 1'h1;
    end
  endtask
endmodule
